/* File: logic/switch_monitor_map.vh */
`ifndef SWITCH_MONITOR_MAP_VH
`define SWITCH_MONITOR_MAP_VH
// Frame length and response field positions (bit 16 of the word is index 15).
`define FRAME_BITS 16
`define RSP_MODE_HI 15
`define RSP_MODE_LO 14
`define RSP_ID_BIT 13
`define RSP_INT_BIT 12
`define RSP_GND_HI 11
`define RSP_GND_LO 6
`define RSP_PRG_HI 5
`define RSP_PRG_LO 2
`define RSP_BAT_HI 1
`define RSP_BAT_LO 0
// Mode encodings.
`define MODE_SLEEP 2'h0
`define MODE_NORMAL 2'h1
`define MODE_POLL 2'h2
`define MODE_POLL_TIMER 2'h3
// Command opcodes in bits [15:12] of the received word.
`define CMD_RUN 4'h1
`define CMD_TRISTATE 4'h3
`define CMD_TEST_BIT 15
`define RUN_MODE_HI 11
`define RUN_MODE_LO 10
// Reset value of the input enable register.
`define ENABLE_RESET 12'h000
`endif

/* File: logic/sync2.v */
`timescale 1ns/10ps
// Two-stage synchroniser for signals arriving from outside the clock domain.
module sync2 #(
  parameter WIDTH = 1
) (
  input wire ref_clk,
  input wire reset_n,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_r;

  // The first stage feeds only the second stage.
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

/* File: logic/switch_monitor_spi_response.v */
// How it works
// - A received word with bit 16 set enters test mode; other bits ignored.
// - Response bits 16:15 report mode: sleep, normal, polling, polling with timer.
// - Response bit 14 mirrors the primary/secondary strap pin, except in sleep, where it reads zero.
// - Response bit 13 is the inverse of the active-low interrupt output, except in sleep, where it reads zero.
// - The interrupt flag stays set while the interrupt remains uncleared.
// - Bits 12:7 ground, 6:3 programmable, 2:1 battery flags; one means closed.
// - Switch states are captured when chip select falls in normal and polling modes.
// - A disabled input always reports zero in its flag.
// - Disabled inputs have wetting and sustain currents off.
// - Reset clears all registers except the select history, which reads deselected, and enters sleep; sleep persists after release.
// - Only an SPI command takes the device out of sleep.
// - Run command mode bits: 01 normal, 10 polling, 11 polling timer, 00 sleep.
// - Reset clears all input enables; inputs stay disabled after leaving sleep.
`timescale 1ns/10ps
`include "switch_monitor_map.vh"
module switch_monitor_spi_response #(
  parameter NUM_GND = 6,
  parameter NUM_PRG = 4,
  parameter NUM_BAT = 2
) (
  input wire ref_clk,
  input wire reset_n,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  output reg spi_miso,
  output wire spi_miso_oe_n,
  input wire primary_secondary_id,
  input wire [NUM_GND-1:0] ground_switch_in,
  input wire [NUM_PRG-1:0] programmable_switch_in,
  input wire [NUM_BAT-1:0] battery_switch_in,
  input wire interrupt_n,
  output wire [NUM_GND-1:0] ground_input_enable,
  output wire [NUM_PRG-1:0] programmable_input_enable,
  output wire [NUM_BAT-1:0] battery_input_enable,
  output wire [NUM_GND-1:0] ground_current_on,
  output wire [NUM_PRG-1:0] programmable_current_on,
  output wire [NUM_BAT-1:0] battery_current_on,
  output reg [1:0] operating_mode_bits,
  output reg test_mode,
  output reg frame_done
);
  localparam NSW = NUM_GND + NUM_PRG + NUM_BAT;
  localparam NIN = 4 + NSW;

  // Two-flop synchronisers for every pin from outside the clock domain.
  wire [NIN-1:0] pins_s;
  sync2 #(
    .WIDTH(NIN)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .async_in({spi_sclk, ~spi_cs_n, spi_mosi, primary_secondary_id,
      ground_switch_in, programmable_switch_in, battery_switch_in}),
    .sync_out(pins_s)
  );

  wire sclk_s = pins_s[NIN-1];
  // Select travels inverted so that the cleared synchroniser reads as deselected.
  wire cs_n_s = ~pins_s[NIN-2];
  wire mosi_s = pins_s[NIN-3];
  wire id_s = pins_s[NIN-4];
  wire [NSW-1:0] sw_s = pins_s[NSW-1:0];

  // Interrupt output of the device is on-chip logic, so it needs no synchroniser.
  reg sclk_d_r;
  reg cs_n_d_r;
  reg [NSW-1:0] enable_r;
  reg [`FRAME_BITS-1:0] shift_out_r;
  reg [`FRAME_BITS-1:0] shift_in_r;
  reg [4:0] bit_cnt_r;

  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire sclk_fall = ~sclk_s & sclk_d_r;
  wire cs_fall = ~cs_n_s & cs_n_d_r;
  wire cs_rise = cs_n_s & ~cs_n_d_r;
  wire in_frame = ~cs_n_s;

  // Disabled inputs report zero and have their currents off.
  wire [NSW-1:0] masked_sw = sw_s & enable_r;
  assign ground_input_enable = enable_r[NSW-1:NUM_PRG+NUM_BAT];
  assign programmable_input_enable = enable_r[NUM_PRG+NUM_BAT-1:NUM_BAT];
  assign battery_input_enable = enable_r[NUM_BAT-1:0];
  assign ground_current_on = ground_input_enable;
  assign programmable_current_on = programmable_input_enable;
  assign battery_current_on = battery_input_enable;

  // The data pin is driven only while chip select is low.
  assign spi_miso_oe_n = cs_n_s;

  // Response word assembled at chip select fall.
  reg [`FRAME_BITS-1:0] response;
  always @*
  begin
    response = {`FRAME_BITS{1'b0}};
    response[`RSP_MODE_HI:`RSP_MODE_LO] = operating_mode_bits;
    if (operating_mode_bits != `MODE_SLEEP)
    begin
      response[`RSP_ID_BIT] = id_s;
      response[`RSP_INT_BIT] = ~interrupt_n;
      response[`RSP_GND_HI:`RSP_BAT_LO] = masked_sw;
    end
  end

  // Edge history of the synchronised link signals.
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      cs_n_d_r <= cs_n_s;
    end
  end

  // Shifter: load on select fall, shift out on falling clock, sample on rising.
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_out_r <= {`FRAME_BITS{1'b0}};
      shift_in_r <= {`FRAME_BITS{1'b0}};
      bit_cnt_r <= 5'h00;
      spi_miso <= 1'b0;
    end
    else if (cs_fall)
    begin
      shift_out_r <= {response[`FRAME_BITS-2:0], 1'b0};
      spi_miso <= response[`FRAME_BITS-1];
      bit_cnt_r <= 5'h00;
    end
    else if (in_frame)
    begin
      if (sclk_rise)
      begin
        shift_in_r <= {shift_in_r[`FRAME_BITS-2:0], mosi_s};
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
      if (sclk_fall)
      begin
        spi_miso <= shift_out_r[`FRAME_BITS-1];
        shift_out_r <= {shift_out_r[`FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  // Command decode at chip select rise after exactly sixteen bits.
  wire cmd_valid = cs_rise & (bit_cnt_r == 5'h10);
  wire [3:0] opcode = shift_in_r[15:12];
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      operating_mode_bits <= `MODE_SLEEP;
      enable_r <= `ENABLE_RESET;
      test_mode <= 1'b0;
      frame_done <= 1'b0;
    end
    else
    begin
      frame_done <= cmd_valid;
      if (cmd_valid)
      begin
        if (shift_in_r[`CMD_TEST_BIT])
          test_mode <= 1'b1;
        else if (opcode == `CMD_RUN)
          operating_mode_bits <= shift_in_r[`RUN_MODE_HI:`RUN_MODE_LO];
        else if (opcode == `CMD_TRISTATE)
          enable_r <= shift_in_r[NSW-1:0];
      end
    end
  end
endmodule

/* File: testbench/switch_monitor_sva.sv */
`timescale 1ns/10ps
module switch_monitor_checker #(
  parameter NUM_GND = 6
) (
  input logic ref_clk,
  input logic reset_n,
  input logic spi_cs_n,
  input logic spi_miso_oe_n,
  input logic [NUM_GND-1:0] ground_input_enable,
  input logic [NUM_GND-1:0] ground_current_on,
  input logic [1:0] operating_mode_bits,
  input logic test_mode,
  input logic frame_done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Outputs that may change only when a command lands, and sticky or tied ones.
  AST_CURR: assert property (ground_current_on == ground_input_enable)
    else $error("current follows no enable");
  AST_OE: assert property (spi_cs_n [*4] |-> spi_miso_oe_n)
    else $error("output driven outside a frame");
  AST_RST: assert property ($rose(reset_n) |-> !test_mode && !ground_input_enable)
    else $error("state not cleared by reset");
  AST_SLEEP: assert property ($rose(reset_n) |-> operating_mode_bits == 2'h0)
    else $error("not asleep after reset");
  AST_MODE: assert property ($changed(operating_mode_bits) |-> frame_done)
    else $error("mode moved without a command");
  AST_ENA: assert property ($changed(ground_input_enable) |-> frame_done)
    else $error("enable moved without a command");
  AST_TEST: assert property (test_mode |=> test_mode)
    else $error("test mode dropped");
  AST_DONE: assert property (frame_done |-> spi_cs_n ##1 !frame_done)
    else $error("frame end inside a frame");
  cover property (frame_done);
  cover property ($rose(test_mode));
  cover property (operating_mode_bits == 2'h3);
endmodule
bind switch_monitor_spi_response switch_monitor_checker #(.NUM_GND(NUM_GND)) chk_u (
  .ref_clk(ref_clk), .reset_n(reset_n), .spi_cs_n(spi_cs_n), .spi_miso_oe_n(spi_miso_oe_n),
  .ground_input_enable(ground_input_enable), .ground_current_on(ground_current_on),
  .operating_mode_bits(operating_mode_bits), .test_mode(test_mode), .frame_done(frame_done));

/* File: testbench/spi_host.sv */
`timescale 1ns/10ps
// Host end of the link; its clock idles low and stands still between frames.
module spi_host (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input logic miso
);
  initial
  begin
    sclk = 1'h0;
    cs_n = 1'h1;
    mosi = 1'h0;
  end
  // Sends a word and gathers the reply, top bit first, then raises chip select and inverts the data line.
  task xfer(input logic [15:0] cmd, output logic [15:0] rsp);
    integer k;
  begin
    cs_n = 1'h0;
    for (k = 15; k >= 0; k--)
    begin
      mosi = cmd[k];
      #400 sclk = 1'h1;
      rsp[k] = miso;
      #400 sclk = 1'h0;
    end
    #400 cs_n = 1'h1;
    mosi = ~mosi;
    #600;
  end
  endtask
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  typedef struct {logic [1:0] m; logic [11:0] en; logic [11:0] sw; logic id; logic irq;} row_t;
  row_t rows [5] = '{'{2'h1, 12'hFFF, 12'hA5C, 1'h1, 1'h1}, '{2'h1, 12'hF0F, 12'hFFF, 1'h0, 1'h0},
    '{2'h2, 12'hFFF, 12'h3C3, 1'h1, 1'h1}, '{2'h3, 12'h0FF, 12'hFFF, 1'h0, 1'h1},
    '{2'h0, 12'hFFF, 12'hFFF, 1'h1, 1'h1}};
  logic ref_clk = 1'h0;
  logic reset_n = 1'h0;
  logic id = 1'h0;
  logic irq_n = 1'h1;
  logic [11:0] sw = 12'h000;
  logic [15:0] rsp;
  logic [15:0] exp;
  wire [1:0] mode;
  wire [5:0] gen;
  wire [3:0] pen;
  wire [1:0] ben;
  wire sclk, cs_n, mosi, miso, tm;
  integer fail_count = 0;
  integer tests_run = 0;
  integer i;
  spi_host host_u (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  switch_monitor_spi_response dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe_n(),
    .primary_secondary_id(id), .ground_switch_in(sw[11:6]), .programmable_switch_in(sw[5:2]),
    .battery_switch_in(sw[1:0]), .interrupt_n(irq_n), .ground_input_enable(gen),
    .programmable_input_enable(pen), .battery_input_enable(ben), .ground_current_on(),
    .programmable_current_on(), .battery_current_on(), .operating_mode_bits(mode),
    .test_mode(tm), .frame_done());
  // The reference clock.
  initial
  forever #50 ref_clk = ~ref_clk;
  // Compares the bits picked by a mask.
  task chk(input logic [15:0] got, input logic [15:0] want, input logic [15:0] msk);
  begin
    tests_run++;
    if ((got & msk) !== (want & msk))
    begin
      fail_count++;
      $display("unexpected at %0t got %h want %h", $time, got, want);
    end
  end
  endtask
  // Prints the counts and the verdict.
  task end_of_test;
  begin
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  // Wakes the part, runs the table, then test mode and a second reset.
  initial
  begin
    repeat (3) @(negedge ref_clk);
    reset_n = 1'h1;
    repeat (3) @(negedge ref_clk);
    chk({4'h0, gen, pen, ben}, 16'h0000, 16'hFFFF);
    host_u.xfer(16'h1400, rsp);
    chk(rsp, 16'h0000, 16'hC000);
    chk({14'h0000, mode}, 16'h0001, 16'hFFFF);
    chk({4'h0, gen, pen, ben}, 16'h0000, 16'hFFFF);
    for (i = 0; i < 5; i++)
    begin
      @(negedge ref_clk);
      sw = rows[i].sw;
      id = rows[i].id;
      irq_n = ~rows[i].irq;
      host_u.xfer({4'h3, rows[i].en}, rsp);
      host_u.xfer({4'h1, rows[i].m, 10'h000}, rsp);
      fork
        host_u.xfer(16'h0000, rsp);
        #2000 sw = ~sw;
      join
      exp = {rows[i].m, rows[i].id, rows[i].irq, rows[i].sw & rows[i].en};
      chk(rsp, exp, rows[i].m == 2'h0 ? 16'hC000 : 16'hEFFF);
      chk(rsp, exp, rows[i].m[0] ? 16'h1000 : 16'h0000);
      chk({4'h0, gen, pen, ben}, {4'h0, rows[i].en}, 16'hFFFF);
    end
    host_u.xfer(16'h8000, rsp);
    chk({15'h0000, tm}, 16'h0001, 16'hFFFF);
    @(negedge ref_clk);
    reset_n = 1'h0;
    @(negedge ref_clk);
    chk({1'h0, tm, mode, gen, pen, ben}, 16'h0000, 16'hFFFF);
    reset_n = 1'h1;
    repeat (3) @(negedge ref_clk);
    end_of_test;
  end
endmodule
